// >>> rtl/fl_erase_pwr_ctrl.sv
`timescale 1ns/1ps
module fl_erase_pwr_ctrl #(
    parameter logic [7:0] OP_ERASE  = fl_pkg::OP_ERASE,
    parameter logic [7:0] OP_SLEEP  = fl_pkg::OP_SLEEP,
    parameter logic [7:0] OP_WAKE   = fl_pkg::OP_WAKE,
    parameter logic [7:0] OP_WRITE_ENABLE_CMD   = fl_pkg::OP_WRITE_ENABLE_CMD,
    parameter int         PUW_CYC   = fl_pkg::PUW_CYC,
    parameter int         ERASE_CYC = fl_pkg::ERASE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        array_protected_i,
    input  wire logic        ext_cycle_busy_i,
    input  wire logic        status_write_busy_i,
    output logic             busy_o,
    output logic             write_enable_latch_o,
    output logic             erase_abort_o,
    output logic             deep_sleep_o,
    output logic             standby_o,
    output logic             lock_clear_o,
    output logic             write_ready_o,
    output logic             fwd_valid_o,
    output logic [7:0]       fwd_code_o
);
    localparam logic [fl_pkg::TMR_W-1:0] PUW_LD   = fl_pkg::TMR_W'(PUW_CYC);
    localparam logic [fl_pkg::TMR_W-1:0] ERASE_LD = fl_pkg::TMR_W'(ERASE_CYC);
    localparam logic [fl_pkg::TMR_W-1:0] DP_LD    = fl_pkg::TMR_W'(fl_pkg::DP_CYC);
    localparam logic [fl_pkg::TMR_W-1:0] RDP_LD   = fl_pkg::TMR_W'(fl_pkg::RDP_CYC);

    fl_pkg::fl_state_e        state_q;
    fl_pkg::fl_state_e        state_d;
    fl_pkg::fl_frame_s        link_frame;
    fl_pkg::fl_frame_s        fr_q;
    logic [2:0]               cs_sync_q;
    logic [1:0]               pin_sync_q;
    logic                     frame_end;
    logic                     rst_req_q;
    logic                     apply_rst;
    logic                     link_clr_q;
    logic                     wel_q;
    logic                     puw_load_q;
    logic                     puw_busy;
    logic                     puw_done_q;
    logic                     tmr_load;
    logic [fl_pkg::TMR_W-1:0] tmr_count;
    logic                     tmr_busy;
    logic                     tmr_done;
    logic                     abort_q;
    logic                     lock_clr_q;
    logic                     fwd_q;
    logic [7:0]               fwd_code_q;
    logic                     is_exact;
    logic                     erase_ok;

    // True when the frame held exactly one code byte.
    function automatic logic exact8(input fl_pkg::fl_frame_s f);
        return f.bits == fl_pkg::CODE_BITS;
    endfunction : exact8

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    // Clearing the link on the reset pin drops any half-decoded code.
    fl_spi_rx u_rx (
        .sclk_i  (sclk_i),
        .clr_i   (link_clr_q),
        .cs_n_i  (cs_n_i),
        .mosi_i  (mosi_i),
        .frame_o (link_frame)
    );

    // ----------------------------------------
    // Crossings
    // ----------------------------------------
    // Chip select and the reset pin pass two flops; the third cs flop feeds edge detection.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_sync_q  <= 3'h7;
            pin_sync_q <= 2'h3;
        end else begin
            cs_sync_q  <= {cs_sync_q[1:0], cs_n_i};
            pin_sync_q <= {pin_sync_q[0], reset_pin_n_i};
        end
    end

    assign frame_end = cs_sync_q[1] & ~cs_sync_q[2];

    // The frame word is quiet once chip select is seen high, so it is taken then.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fr_q <= '0;
        end else if (frame_end) begin
            fr_q <= link_frame;
        end
    end

    // ----------------------------------------
    // Reset pin handling
    // ----------------------------------------
    // A low pulse is held until applied, so a short pulse is never lost; set wins.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_req_q <= 1'b0;
        end else if (!pin_sync_q[1]) begin
            rst_req_q <= 1'b1;
        end else if (apply_rst) begin
            rst_req_q <= 1'b0;
        end
    end

    // A status write in flight is let run out before the reset takes hold.
    assign apply_rst = rst_req_q & ~status_write_busy_i;

    // ----------------------------------------
    // Power-up write delay
    // ----------------------------------------
    // The delay counts from detector release only; the reset pin does not restart it.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            puw_load_q <= 1'b1;
            puw_done_q <= 1'b0;
        end else begin
            puw_load_q <= 1'b0;
            if (!puw_load_q && !puw_busy) begin
                puw_done_q <= 1'b1;
            end
        end
    end

    fl_timer u_puw (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (1'b0),
        .load_i  (puw_load_q),
        .count_i (PUW_LD),
        .busy_o  (puw_busy),
        .done_o  ()
    );

    // ----------------------------------------
    // Command decode and state
    // ----------------------------------------
    assign is_exact = exact8(fr_q);
    assign erase_ok = is_exact & (fr_q.code == OP_ERASE) & wel_q & puw_done_q
                    & ~array_protected_i & ~ext_cycle_busy_i;

    // Decode uses fr_q one cycle after frame_end, so a delayed strobe is kept.
    logic dec_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_q <= 1'b0;
        end else begin
            dec_q <= frame_end;
        end
    end

    always_comb begin
        state_d   = state_q;
        tmr_load  = 1'b0;
        tmr_count = '0;
        case (state_q)
            fl_pkg::ST_STANDBY: begin
                if (dec_q && erase_ok) begin
                    state_d   = fl_pkg::ST_ERASE;
                    tmr_load  = 1'b1;
                    tmr_count = ERASE_LD;
                end else if (dec_q && is_exact && fr_q.code == OP_SLEEP
                             && !ext_cycle_busy_i) begin
                    state_d   = fl_pkg::ST_ENTRY;
                    tmr_load  = 1'b1;
                    tmr_count = DP_LD;
                end
            end
            fl_pkg::ST_ERASE: begin
                // Every frame is refused here as far as this block is concerned.
                if (tmr_done) begin
                    state_d = fl_pkg::ST_STANDBY;
                end
            end
            fl_pkg::ST_ENTRY: begin
                if (tmr_done) begin
                    state_d = fl_pkg::ST_SLEEP;
                end
            end
            fl_pkg::ST_SLEEP: begin
                if (dec_q && is_exact && fr_q.code == OP_WAKE && !ext_cycle_busy_i) begin
                    state_d   = fl_pkg::ST_WAKE;
                    tmr_load  = 1'b1;
                    tmr_count = RDP_LD;
                end
            end
            fl_pkg::ST_WAKE: begin
                if (tmr_done) begin
                    state_d = fl_pkg::ST_STANDBY;
                end
            end
            fl_pkg::ST_RESET: begin
                if (pin_sync_q[1] && !rst_req_q) begin
                    state_d = fl_pkg::ST_STANDBY;
                end
            end
            default: begin
                state_d = fl_pkg::ST_STANDBY;
            end
        endcase
        if (apply_rst) begin
            state_d  = fl_pkg::ST_RESET;
            tmr_load = 1'b0;
        end
    end

    // Power-on always lands in standby, never in sleep.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= fl_pkg::ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    fl_timer u_cyc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (apply_rst),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .busy_o  (tmr_busy),
        .done_o  (tmr_done)
    );

    // ----------------------------------------
    // Write enable latch
    // ----------------------------------------
    // Cleared as the erase starts, which is well before it ends.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_q <= 1'b0;
        end else if (apply_rst || (state_q == fl_pkg::ST_STANDBY && dec_q && erase_ok)) begin
            wel_q <= 1'b0;
        end else if (dec_q && is_exact && fr_q.code == OP_WRITE_ENABLE_CMD && puw_done_q
                     && state_q == fl_pkg::ST_STANDBY) begin
            wel_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Abort, lock clear and link clear
    // ----------------------------------------
    // Lock bits are cleared at power-on and whenever the pin reset takes hold.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            abort_q    <= 1'b0;
            lock_clr_q <= 1'b1;
            link_clr_q <= 1'b1;
        end else begin
            abort_q    <= apply_rst & (state_q == fl_pkg::ST_ERASE);
            lock_clr_q <= apply_rst;
            link_clr_q <= apply_rst | (state_q == fl_pkg::ST_RESET);
        end
    end

    // ----------------------------------------
    // Forwarding to other command blocks
    // ----------------------------------------
    // Other codes go on, also before the write delay ends; sleep entry, sleep, wake and reset block them.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fwd_q      <= 1'b0;
            fwd_code_q <= 8'h00;
        end else begin
            fwd_q <= dec_q & ~apply_rst
                   & (state_q == fl_pkg::ST_STANDBY || state_q == fl_pkg::ST_ERASE)
                   & fr_q.code != OP_ERASE & fr_q.code != OP_SLEEP
                   & fr_q.code != OP_WAKE & fr_q.code != OP_WRITE_ENABLE_CMD;
            if (dec_q) begin
                fwd_code_q <= fr_q.code;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign busy_o               = (state_q == fl_pkg::ST_ERASE);
    assign write_enable_latch_o = wel_q;
    assign erase_abort_o        = abort_q;
    assign deep_sleep_o         = (state_q == fl_pkg::ST_SLEEP);
    // Deselect alone never means sleep, and a running cycle blocks standby.
    assign standby_o            = (state_q == fl_pkg::ST_STANDBY) & cs_sync_q[2]
                                & ~ext_cycle_busy_i;
    assign lock_clear_o         = lock_clr_q;
    assign write_ready_o        = puw_done_q;
    assign fwd_valid_o          = fwd_q;
    assign fwd_code_o           = fwd_code_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    erase_needs_wel_a: assert property ($rose(busy_o) |-> $past(wel_q))
        else $error("erase started without write enable latch");

    erase_exact_a: assert property ($rose(busy_o) |-> $past(is_exact && !array_protected_i))
        else $error("erase started from a bad frame");

    erase_busy_a: assert property ($rose(busy_o) |-> busy_o [*2] ##0 tmr_busy)
        else $error("busy flag did not cover the erase");

    wel_cleared_a: assert property (busy_o |-> !wel_q)
        else $error("latch still set during erase");

    busy_reject_a: assert property (busy_o && !apply_rst && !tmr_done |=> busy_o)
        else $error("running erase disturbed");

    protect_block_a: assert property (dec_q && array_protected_i |=> !$rose(busy_o))
        else $error("erase ran with a protected area");

    reset_abort_a: assert property (busy_o && apply_rst |=> erase_abort_o && lock_clear_o
                                    && state_q == fl_pkg::ST_RESET)
        else $error("reset did not abort erase");

    sleep_hold_a: assert property (deep_sleep_o && !(dec_q && fr_q.code == OP_WAKE)
                                   && !apply_rst |=> deep_sleep_o && !fwd_valid_o)
        else $error("sleep left without wake");

    sleep_entry_a: assert property ($rose(deep_sleep_o) |-> $past(state_q == fl_pkg::ST_ENTRY))
        else $error("sleep entered without delay");

    wake_extra_a: assert property (deep_sleep_o && dec_q && !is_exact && !apply_rst
                                   |=> deep_sleep_o)
        else $error("wake with extra clocks accepted");

    puw_gate_a: assert property (!puw_done_q |-> !wel_q && !busy_o)
        else $error("write accepted before write delay");

    status_defer_a: assert property (rst_req_q && status_write_busy_i
                                     && state_q != fl_pkg::ST_RESET |=> state_q != fl_pkg::ST_RESET)
        else $error("reset cut a status write");

endmodule : fl_erase_pwr_ctrl

// >>> rtl/fl_pkg.sv
package fl_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ    = 40;
    localparam int T_PUW_NS   = 1000000;  // Least power-up write delay, 1 ms.
    localparam int T_DP_NS    = 3000;     // Sleep entry delay.
    localparam int T_RDP_NS   = 3000;     // Wake delay.
    localparam int T_ERASE_NS = 2000000;  // Whole-array erase time.
    localparam int TMR_W      = 24;

    // Least times round up, and never fall under one cycle.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int PUW_CYC   = ns_to_cyc(T_PUW_NS);
    localparam int DP_CYC    = ns_to_cyc(T_DP_NS);
    localparam int RDP_CYC   = ns_to_cyc(T_RDP_NS);
    localparam int ERASE_CYC = ns_to_cyc(T_ERASE_NS);

    // ----------------------------------------
    // Frame layout and codes
    // ----------------------------------------
    localparam logic [3:0] CODE_BITS = 4'h8;
    localparam logic [3:0] BITS_SAT  = 4'h9;
    localparam logic [7:0] OP_ERASE  = 8'ha1;  // Arbitrary default codes.
    localparam logic [7:0] OP_SLEEP  = 8'ha2;
    localparam logic [7:0] OP_WAKE   = 8'ha3;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'ha4;

    typedef struct packed {
        logic [3:0] bits;
        logic [7:0] code;
    } fl_frame_s;

    typedef enum {ST_STANDBY, ST_ERASE, ST_ENTRY, ST_SLEEP, ST_WAKE, ST_RESET} fl_state_e;

endpackage : fl_pkg

// >>> rtl/fl_spi_rx.sv
`timescale 1ns/1ps
module fl_spi_rx (
    input  wire logic        sclk_i,
    input  wire logic        clr_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output fl_pkg::fl_frame_s frame_o
);
    logic              first_q;
    fl_pkg::fl_frame_s frame_q;
    logic              first_rst;

    // ----------------------------------------
    // Frame start and shift register
    // ----------------------------------------
    // The serial clock stops between frames, so the start is armed by chip select itself.
    assign first_rst = cs_n_i | clr_i;

    always_ff @(posedge sclk_i or posedge first_rst) begin
        if (first_rst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // The word holds after the frame until the next first edge, for the other domain.
    always_ff @(posedge sclk_i or posedge clr_i) begin
        if (clr_i) begin
            frame_q <= '0;
        end else if (!cs_n_i) begin
            if (first_q) begin
                frame_q.bits <= 4'h1;
                frame_q.code <= {7'h00, mosi_i};
            end else begin
                if (frame_q.bits != fl_pkg::BITS_SAT) begin
                    frame_q.bits <= frame_q.bits + 4'h1;
                end
                frame_q.code <= {frame_q.code[6:0], mosi_i};
            end
        end
    end

    assign frame_o = frame_q;

endmodule : fl_spi_rx

// >>> rtl/fl_timer.sv
`timescale 1ns/1ps
module fl_timer (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    clr_i,
    input  wire logic                    load_i,
    input  wire logic [fl_pkg::TMR_W-1:0] count_i,
    output logic                         busy_o,
    output logic                         done_o
);
    logic [fl_pkg::TMR_W-1:0] cnt_q;
    logic                     done_q;

    // ----------------------------------------
    // Down counter
    // ----------------------------------------
    // A load restarts the count; done pulses one cycle after the last count.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (clr_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (load_i) begin
            cnt_q  <= count_i;
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == 1);
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;

endmodule : fl_timer

// >>> sim/fl_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial host model
// ----------------------------------------
module fl_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // The link clock runs only inside frames and stands low between them.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Sends a code MSB first over nclk link clocks; clocks past eight carry zero.
    task automatic send(input logic [7:0] code, input int nclk);
        cs_n_o = 1'b0;
        for (int k = 0; k < nclk; k++) begin
            mosi_o = (k < 8) ? code[7-k] : 1'b0;
            #3 sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale value.
        #150; // Deselect gap keeps the frame word until decoded.
    endtask : send
endmodule : fl_host_model

// >>> sim/test_fl_erase_pwr_ctrl.sv
`timescale 1ns/1ps
module test_fl_erase_pwr_ctrl;
    localparam int PUW = 20;
    localparam int ERA = 30;
    logic       clk_i, rst_i, reset_pin_n_i, array_protected_i;
    logic       ext_cycle_busy_i, status_write_busy_i;
    logic       sclk, cs_n, mosi;
    logic       busy_o, write_enable_latch_o, erase_abort_o, deep_sleep_o, standby_o;
    logic       lock_clear_o, write_ready_o, fwd_valid_o, seen_a, seen_b;
    logic [7:0] fwd_code_o, code_q;
    int         fail_count = 0;
    int         checked    = 0;
    int         fwd_n      = 0;

    fl_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    fl_erase_pwr_ctrl #(.PUW_CYC(PUW), .ERASE_CYC(ERA)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .reset_pin_n_i(reset_pin_n_i), .array_protected_i(array_protected_i),
        .ext_cycle_busy_i(ext_cycle_busy_i), .status_write_busy_i(status_write_busy_i),
        .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
        .erase_abort_o(erase_abort_o), .deep_sleep_o(deep_sleep_o), .standby_o(standby_o),
        .lock_clear_o(lock_clear_o), .write_ready_o(write_ready_o),
        .fwd_valid_o(fwd_valid_o), .fwd_code_o(fwd_code_o));

    // ----------------------------------------
    // Clock, checks and closing
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Sends a frame, then gives decode time; the pulse lands inside the deselect gap,
    // so the monitor below counts it while the host is still waiting.
    task automatic frame(input logic [7:0] code, input int nclk);
        int n0;
        n0 = fwd_n;
        host.send(code, nclk);
        cyc(4);
        seen_a = (fwd_n != n0);
    endtask : frame

    // One-cycle forward pulses are caught at the falling edge, where they are settled.
    always @(negedge clk_i) begin
        if (fwd_valid_o === 1'b1) begin
            fwd_n++;
            code_q = fwd_code_o;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    // The whole run needs well under a tenth of this span.
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst_i = 1'b1;
        reset_pin_n_i = 1'b1;
        array_protected_i = 1'b0;
        ext_cycle_busy_i = 1'b0;
        status_write_busy_i = 1'b0;
        cyc(11);
        chk(lock_clear_o, 1);
        chk(standby_o, 1);
        chk({busy_o, write_enable_latch_o, deep_sleep_o}, 0);
        @(posedge clk_i) rst_i <= 1'b0;
        cyc(3);
        chk(lock_clear_o, 0);
        frame(fl_pkg::OP_WRITE_ENABLE_CMD, 8);
        chk(write_ready_o, 0);
        chk(write_enable_latch_o, 0);
        frame(8'h5a, 8);
        chk(seen_a, 1);
        chk(code_q, 8'h5a);
        cyc(PUW);
        chk(write_ready_o, 1);
        frame(fl_pkg::OP_ERASE, 8);
        chk(busy_o, 0);
        frame(fl_pkg::OP_WRITE_ENABLE_CMD, 8);
        chk(write_enable_latch_o, 1);
        frame(fl_pkg::OP_ERASE, 9);
        chk(busy_o, 0);
        @(posedge clk_i) array_protected_i <= 1'b1;
        frame(fl_pkg::OP_ERASE, 8);
        chk(busy_o, 0);
        @(posedge clk_i) array_protected_i <= 1'b0;
        frame(fl_pkg::OP_ERASE, 8);
        chk(busy_o, 1);
        chk(write_enable_latch_o, 0);
        chk(standby_o, 0);
        frame(fl_pkg::OP_SLEEP, 8);
        for (int k = 0; k < ERA + 10 && busy_o !== 1'b0; k++) cyc(1);
        chk(busy_o, 0);
        cyc(130);
        chk(deep_sleep_o, 0);
        chk(standby_o, 1);
        // A pin reset in mid-erase aborts it and clears the locks.
        frame(fl_pkg::OP_WRITE_ENABLE_CMD, 8);
        frame(fl_pkg::OP_ERASE, 8);
        chk(busy_o, 1);
        @(posedge clk_i) reset_pin_n_i <= 1'b0;
        seen_a = 1'b0;
        seen_b = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (k == 4) reset_pin_n_i <= 1'b1;
            cyc(1);
            seen_a |= erase_abort_o;
            seen_b |= lock_clear_o;
        end
        chk({seen_a, seen_b}, 2'h3);
        chk({busy_o, write_enable_latch_o}, 0);
        cyc(6);
        chk(standby_o, 1);
        // A code sent while the pin holds reset is dropped.
        @(posedge clk_i) reset_pin_n_i <= 1'b0;
        frame(fl_pkg::OP_WRITE_ENABLE_CMD, 8);
        reset_pin_n_i <= 1'b1;
        cyc(8);
        chk({write_enable_latch_o, standby_o}, 2'h1);
        // A pin reset during a status write waits for the write to finish.
        @(posedge clk_i) status_write_busy_i <= 1'b1;
        reset_pin_n_i <= 1'b0;
        cyc(6);
        reset_pin_n_i <= 1'b1;
        cyc(4);
        chk({lock_clear_o, standby_o}, 2'h1);
        status_write_busy_i <= 1'b0;
        seen_b = 1'b0;
        for (int k = 0; k < 8; k++) begin
            cyc(1);
            seen_b |= lock_clear_o;
        end
        chk(seen_b, 1);
        chk(standby_o, 1);
        // Sleep entry, wrong lengths and wake.
        @(posedge clk_i) ext_cycle_busy_i <= 1'b1;
        frame(fl_pkg::OP_SLEEP, 8);
        chk(standby_o, 0);
        @(posedge clk_i) ext_cycle_busy_i <= 1'b0;
        cyc(130);
        chk(deep_sleep_o, 0);
        frame(fl_pkg::OP_SLEEP, 7);
        cyc(130);
        chk(deep_sleep_o, 0);
        frame(fl_pkg::OP_SLEEP, 8);
        for (int k = 0; k < 140 && deep_sleep_o !== 1'b1; k++) cyc(1);
        chk(deep_sleep_o, 1);
        frame(fl_pkg::OP_WRITE_ENABLE_CMD, 8);
        chk({write_enable_latch_o, seen_a}, 0);
        frame(fl_pkg::OP_WAKE, 9);
        chk(deep_sleep_o, 1);
        frame(fl_pkg::OP_WAKE, 8);
        chk(deep_sleep_o, 0);
        chk(standby_o, 0);
        for (int k = 0; k < 140 && standby_o !== 1'b1; k++) cyc(1);
        chk(standby_o, 1);
        end_sim();
    end
endmodule : test_fl_erase_pwr_ctrl
